// *** logic/compare_b_value_pkg.sv ***
// package: register map, field positions, encodings for the compare-b channel
`default_nettype none
package compare_b_value_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [3:0] COMPARE_B_VALUE_ADDR_VALUE = 4'h0;
	localparam logic [3:0] COMPARE_B_VALUE_ADDR_CTRL = 4'h1;
	localparam logic [15:0] COMPARE_B_VALUE_CTRL_RESET = 16'h0000;
	localparam logic [15:0] COMPARE_B_VALUE_VALUE_RESET = 16'h0000;
	localparam logic [15:0] COMPARE_B_VALUE_ZERO_COUNT = 16'h0000;
	// ****************************************
	// control register fields
	// ****************************************
	localparam int COMPARE_B_VALUE_POS_B_PEND = 9;
	localparam int COMPARE_B_VALUE_POS_A_PEND = 8;
	localparam int COMPARE_B_VALUE_POS_B_MODE = 6;
	localparam int COMPARE_B_VALUE_POS_A_MODE = 4;
	localparam int COMPARE_B_VALUE_POS_B_LSEL = 2;
	localparam int COMPARE_B_VALUE_POS_A_LSEL = 0;
	// ****************************************
	// load-select encodings
	// ****************************************
	typedef enum logic [1:0] {
		COMPARE_B_VALUE_LOAD_ZERO = 2'h0,
		COMPARE_B_VALUE_LOAD_PERIOD = 2'h1,
		COMPARE_B_VALUE_LOAD_EITHER = 2'h2,
		COMPARE_B_VALUE_LOAD_FREEZE = 2'h3
	} compare_b_value_lsel_t;
	// ****************************************
	// action-qualifier encodings
	// ****************************************
	typedef enum logic [1:0] {
		COMPARE_B_VALUE_ACT_NONE = 2'h0,
		COMPARE_B_VALUE_ACT_CLEAR = 2'h1,
		COMPARE_B_VALUE_ACT_SET = 2'h2,
		COMPARE_B_VALUE_ACT_TOGGLE = 2'h3
	} compare_b_value_act_t;
endpackage
`default_nettype wire

// *** logic/compare_b_value_bus_if.sv ***
// interface: shadow-register channel signals between top and compare holder
`default_nettype none
interface compare_b_value_bus_if;
	logic wr_value;
	logic [15:0] wdata;
	logic buffer_mode;
	logic load_strobe;
	logic [15:0] active;
	logic [15:0] shadow;
	logic pending;
	modport holder (
		input wr_value, wdata, buffer_mode, load_strobe,
		output active, shadow, pending
	);
	modport user (
		output wr_value, wdata, buffer_mode, load_strobe,
		input active, shadow, pending
	);
endinterface
`default_nettype wire

// *** logic/compare_b_value_holder.sv ***
// module: active and shadow copies of one compare value with pending flag
`default_nettype none
module compare_b_value_holder
	import compare_b_value_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	// channel
	compare_b_value_bus_if.holder bus
);
	logic [15:0] active_q, active_d;
	logic [15:0] shadow_q, shadow_d;
	logic pending_q, pending_d;

	// ****************************************
	// next-value logic
	// ****************************************
	always_comb
	begin
		active_d = active_q;
		shadow_d = shadow_q;
		pending_d = pending_q;
		if (bus.buffer_mode)
		begin
			// immediate: load strobe ignored, writes hit active copy
			if (bus.wr_value)
				active_d = bus.wdata;
			pending_d = 1'b0;
		end
		else
		begin
			// load happens first, a same-cycle write lands afterwards
			if (bus.load_strobe)
			begin
				active_d = shadow_q;
				pending_d = 1'b0;
			end
			if (bus.wr_value)
			begin
				shadow_d = bus.wdata; // overwrite while pending
				pending_d = 1'b1;
			end
		end
	end

	// registers
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			active_q <= COMPARE_B_VALUE_VALUE_RESET;
			shadow_q <= COMPARE_B_VALUE_VALUE_RESET;
			pending_q <= 1'b0;
		end
		else
		begin
			active_q <= active_d;
			shadow_q <= shadow_d;
			pending_q <= pending_d;
		end
	end

	assign bus.active = active_q;
	assign bus.shadow = shadow_q;
	assign bus.pending = pending_q;
endmodule
`default_nettype wire

// *** logic/compare_b_value_top.sv ***
// module: compare-b channel with shadow buffering, control register, action outputs
`default_nettype none
module compare_b_value_top
	import compare_b_value_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	// register port
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	// time base
	input wire logic [15:0] i_time_base_count,
	input wire logic i_count_eq_period,
	// compare-a joins
	input wire logic i_compare_a_pending_flag,
	// action configuration for this event
	input wire logic [1:0] i_action_config_out_a,
	input wire logic [1:0] i_action_config_out_b,
	// outputs
	output logic o_count_eq_compare_b,
	output logic o_pwm_output_a,
	output logic o_pwm_output_b
);
	compare_b_value_bus_if bus ();

	// control register fields
	logic compare_b_buffer_mode_q, compare_b_buffer_mode_d;
	logic compare_a_buffer_mode_q, compare_a_buffer_mode_d;
	logic [1:0] compare_b_load_select_q, compare_b_load_select_d;
	logic [1:0] compare_a_load_select_q, compare_a_load_select_d;

	// read data and compare outputs
	logic [15:0] rdata_q, rdata_d;
	logic event_q, event_d;
	logic [1:0] pwm_q, pwm_d; // index 0 output a, index 1 output b

	// combinational helpers
	logic at_zero;
	logic [15:0] ctrl_view;
	logic equal_now;
	logic wr_ctrl_hit;
	logic rd_value_hit;
	logic rd_ctrl_hit;
	compare_b_value_act_t act_cfg [2];

	// ****************************************
	// register port decode
	// ****************************************
	// strobes are one-cycle pulses and the slave never stalls, so every hit
	// acts on the very edge that samples it; there is no wait state and no
	// second chance for a request
	assign bus.wr_value = i_wr && (i_addr == COMPARE_B_VALUE_ADDR_VALUE); // single address
	assign wr_ctrl_hit = i_wr && (i_addr == COMPARE_B_VALUE_ADDR_CTRL);
	assign rd_value_hit = i_rd && (i_addr == COMPARE_B_VALUE_ADDR_VALUE);
	assign rd_ctrl_hit = i_rd && (i_addr == COMPARE_B_VALUE_ADDR_CTRL);

	// ****************************************
	// shadow holder
	// ****************************************
	assign at_zero = (i_time_base_count == COMPARE_B_VALUE_ZERO_COUNT);
	assign bus.wdata = i_wdata;
	assign bus.buffer_mode = compare_b_buffer_mode_q;

	// load strobe from the selected counter event; it follows the count
	// directly, so a counter parked on a load point strobes every cycle and
	// a write in such a cycle still lands in the shadow after the load
	always_comb
	begin
		bus.load_strobe = 1'b0;
		unique case (compare_b_value_lsel_t'(compare_b_load_select_q))
			COMPARE_B_VALUE_LOAD_ZERO: bus.load_strobe = at_zero;
			COMPARE_B_VALUE_LOAD_PERIOD: bus.load_strobe = i_count_eq_period;
			COMPARE_B_VALUE_LOAD_EITHER: bus.load_strobe = at_zero || i_count_eq_period;
			COMPARE_B_VALUE_LOAD_FREEZE: bus.load_strobe = 1'b0;
		endcase
	end

	// both copies and the pending flag live in the holder; in immediate mode
	// it ignores the strobe, so the select field is dormant there
	compare_b_value_holder u_holder (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.bus(bus)
	);

	// ****************************************
	// control register view
	// ****************************************
	// compare-a mode and select are plain storage in this block; only the
	// compare-a pending flag comes in from outside, and it is shown as it
	// stands in the cycle of the read
	always_comb
	begin
		ctrl_view = COMPARE_B_VALUE_CTRL_RESET; // reserved bits read zero
		ctrl_view[COMPARE_B_VALUE_POS_B_PEND] = bus.pending;
		ctrl_view[COMPARE_B_VALUE_POS_A_PEND] = i_compare_a_pending_flag;
		ctrl_view[COMPARE_B_VALUE_POS_B_MODE] = compare_b_buffer_mode_q;
		ctrl_view[COMPARE_B_VALUE_POS_A_MODE] = compare_a_buffer_mode_q;
		ctrl_view[COMPARE_B_VALUE_POS_B_LSEL +: 2] = compare_b_load_select_q;
		ctrl_view[COMPARE_B_VALUE_POS_A_LSEL +: 2] = compare_a_load_select_q;
	end

	// register writes and read data; the pending flags are not storage here,
	// so a control write never sets them, but selecting immediate mode clears the compare-b one
	always_comb
	begin
		compare_b_buffer_mode_d = compare_b_buffer_mode_q;
		compare_a_buffer_mode_d = compare_a_buffer_mode_q;
		compare_b_load_select_d = compare_b_load_select_q;
		compare_a_load_select_d = compare_a_load_select_q;
		rdata_d = 16'h0000;
		if (wr_ctrl_hit)
		begin
			// pending flags and reserved bits are read-only
			compare_b_buffer_mode_d = i_wdata[COMPARE_B_VALUE_POS_B_MODE];
			compare_a_buffer_mode_d = i_wdata[COMPARE_B_VALUE_POS_A_MODE];
			compare_b_load_select_d = i_wdata[COMPARE_B_VALUE_POS_B_LSEL +: 2];
			compare_a_load_select_d = i_wdata[COMPARE_B_VALUE_POS_A_LSEL +: 2];
		end
		// read data fall back to zero outside a read, unmapped reads too;
		// the mode bit picks which copy the value address shows
		if (rd_value_hit)
			rdata_d = compare_b_buffer_mode_q ? bus.active : bus.shadow;
		else if (rd_ctrl_hit)
			rdata_d = ctrl_view;
	end

	// ****************************************
	// compare event and action stage
	// ****************************************
	assign equal_now = (bus.active == i_time_base_count);
	assign act_cfg[0] = compare_b_value_act_t'(i_action_config_out_a);
	assign act_cfg[1] = compare_b_value_act_t'(i_action_config_out_b);

	// event is registered so it appears in the same cycle as the output
	// update that it causes
	always_comb
	begin
		event_d = equal_now;
	end

	// one action decoder per output: index 0 is output a, index 1 output b;
	// each output follows its own configuration for this one event
	for (genvar g = 0; g < 2; g++)
	begin : g_action
		always_comb
		begin
			pwm_d[g] = pwm_q[g];
			if (equal_now)
			begin
				// toggle reads the registered level, so a held match flips every cycle
				unique case (act_cfg[g])
					COMPARE_B_VALUE_ACT_NONE: pwm_d[g] = pwm_q[g];
					COMPARE_B_VALUE_ACT_CLEAR: pwm_d[g] = 1'b0;
					COMPARE_B_VALUE_ACT_SET: pwm_d[g] = 1'b1;
					COMPARE_B_VALUE_ACT_TOGGLE: pwm_d[g] = !pwm_q[g];
				endcase
			end
		end
	end

	// ****************************************
	// state registers
	// ****************************************
	// all reset to zero: buffered mode, select zero, flags clear
	// read data reset to zero so nothing stands before the first read
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			compare_b_buffer_mode_q <= 1'b0;
			compare_a_buffer_mode_q <= 1'b0;
			compare_b_load_select_q <= 2'h0;
			compare_a_load_select_q <= 2'h0;
			rdata_q <= 16'h0000;
			event_q <= 1'b0;
			pwm_q <= 2'h0;
		end
		else
		begin
			compare_b_buffer_mode_q <= compare_b_buffer_mode_d;
			compare_a_buffer_mode_q <= compare_a_buffer_mode_d;
			compare_b_load_select_q <= compare_b_load_select_d;
			compare_a_load_select_q <= compare_a_load_select_d;
			rdata_q <= rdata_d;
			event_q <= event_d;
			pwm_q <= pwm_d;
		end
	end


	// ****************************************
	// outputs
	// ****************************************
	// every output is a flip-flop, so nothing combinational reaches a pin
	assign o_rdata = rdata_q;
	assign o_count_eq_compare_b = event_q;
	assign o_pwm_output_a = pwm_q[0];
	assign o_pwm_output_b = pwm_q[1];
endmodule
`default_nettype wire

// *** sim/compare_b_value_props.sv ***
// checker: port-level properties of the compare-b channel
`default_nettype none
module compare_b_value_props
	import compare_b_value_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	// register port
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [15:0] o_rdata,
	// time base and actions
	input wire logic [15:0] i_time_base_count,
	input wire logic i_count_eq_period,
	input wire logic i_compare_a_pending_flag,
	input wire logic [1:0] i_action_config_out_a,
	input wire logic [1:0] i_action_config_out_b,
	input wire logic o_count_eq_compare_b,
	input wire logic o_pwm_output_a,
	input wire logic o_pwm_output_b
);
	timeunit 1ns;
	timeprecision 1ps;
	// ********
	// properties
	// ********
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
		else $error("read data not idle");
	a_ctrl_reserved: assert property ($past(i_rd && i_addr == COMPARE_B_VALUE_ADDR_CTRL) |->
		o_rdata[15:10] == 6'h00 && !o_rdata[7] && !o_rdata[5]) else $error("reserved set");
	a_ctrl_apend: assert property ($past(i_rd && i_addr == COMPARE_B_VALUE_ADDR_CTRL) |->
		o_rdata[8] == $past(i_compare_a_pending_flag)) else $error("bit 8 wrong");
	a_unmapped_zero: assert property ($past(i_rd && i_addr > COMPARE_B_VALUE_ADDR_CTRL) |->
		o_rdata == 16'h0000) else $error("unmapped read");
	a_set_out_a: assert property (o_count_eq_compare_b &&
		$past(i_action_config_out_a) == COMPARE_B_VALUE_ACT_SET |-> o_pwm_output_a) else $error("set a");
	a_clear_out_a: assert property (o_count_eq_compare_b &&
		$past(i_action_config_out_a) == COMPARE_B_VALUE_ACT_CLEAR |-> !o_pwm_output_a) else $error("clr a");
	a_toggle_out_b: assert property (o_count_eq_compare_b &&
		$past(i_action_config_out_b) == COMPARE_B_VALUE_ACT_TOGGLE |->
		o_pwm_output_b != $past(o_pwm_output_b)) else $error("toggle b");
	a_hold_out_b: assert property (!o_count_eq_compare_b ||
		$past(i_action_config_out_b) == COMPARE_B_VALUE_ACT_NONE |-> $stable(o_pwm_output_b))
		else $error("hold b");
	c_event: cover property (o_count_eq_compare_b && o_pwm_output_a);
	c_pending: cover property ($past(i_rd && i_addr == COMPARE_B_VALUE_ADDR_CTRL) && o_rdata[9]);
	c_mode: cover property ($past(i_rd && i_addr == COMPARE_B_VALUE_ADDR_CTRL) && o_rdata[6]);
endmodule
bind compare_b_value_top compare_b_value_props i_props (
	.i_core_clk(i_core_clk),
	.i_rst_b(i_rst_b),
	.i_addr(i_addr),
	.i_wdata(i_wdata),
	.i_wr(i_wr),
	.i_rd(i_rd),
	.o_rdata(o_rdata),
	.i_time_base_count(i_time_base_count),
	.i_count_eq_period(i_count_eq_period),
	.i_compare_a_pending_flag(i_compare_a_pending_flag),
	.i_action_config_out_a(i_action_config_out_a),
	.i_action_config_out_b(i_action_config_out_b),
	.o_count_eq_compare_b(o_count_eq_compare_b),
	.o_pwm_output_a(o_pwm_output_a),
	.o_pwm_output_b(o_pwm_output_b)
);
`default_nettype wire

// *** sim/compare_b_value_time_base.sv ***
// model: time-base counter feeding the compare-b channel
`default_nettype none
module compare_b_value_time_base
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	// control
	input wire logic i_run,
	input wire logic [15:0] i_period,
	// counter view
	output logic [15:0] o_count,
	output logic o_at_period
);
	timeunit 1ns;
	timeprecision 1ps;
	// up-count with wrap; parks off the load points after reset
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_count <= 16'h0001;
		else if (i_run)
			o_count <= o_at_period ? 16'h0000 : o_count + 16'h0001;
	end
	assign o_at_period = (o_count == i_period);
endmodule
`default_nettype wire

// *** sim/test_compare_b_channel_shadow.sv ***
// testbench: register and compare tests of the compare-b channel
`default_nettype none
module test_compare_b_channel_shadow
	import compare_b_value_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_b, wr, rd, run, apend, at_prd, ev, pwm_a, pwm_b;
	logic [3:0] addr;
	logic [15:0] wdata, rdata, count;
	logic [1:0] cfg_a, cfg_b;
	int err_count, checked;
	compare_b_value_time_base i_model (.i_core_clk(clk), .i_rst_b(rst_b), .i_run(run),
		.i_period(16'h0007), .o_count(count), .o_at_period(at_prd));
	compare_b_value_top i_dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_time_base_count(count),
		.i_count_eq_period(at_prd), .i_compare_a_pending_flag(apend),
		.i_action_config_out_a(cfg_a), .i_action_config_out_b(cfg_b),
		.o_count_eq_compare_b(ev), .o_pwm_output_a(pwm_a), .o_pwm_output_b(pwm_b));
	// ********
	// tasks
	// ********
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp)
		begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			err_count++;
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp, input string what);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(what, exp, rdata);
	endtask
	task automatic run_cycles(input int n);
		@(posedge clk);
		run <= 1'b1;
		repeat (n) @(posedge clk);
		run <= 1'b0;
	endtask
	task automatic wait_ev(input logic [15:0] exp);
		int n;
		n = 0;
		run <= 1'b1;
		while (ev !== 1'b1 && n < 40)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		run <= 1'b0;
		chk("event seen", 16'h0001, {15'h0000, ev});
		chk("event count", exp, count);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// clock and watchdog
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial
	begin
		#20000;
		err_count++;
		end_of_test;
	end
	// ********
	// tests
	// ********
	initial
	begin
		{rst_b, wr, rd, run, apend} = 5'h00;
		addr = 4'h0;
		wdata = 16'h0000;
		cfg_a = COMPARE_B_VALUE_ACT_SET;
		cfg_b = COMPARE_B_VALUE_ACT_TOGGLE;
		err_count = 0;
		checked = 0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		rd_reg(COMPARE_B_VALUE_ADDR_CTRL, COMPARE_B_VALUE_CTRL_RESET, "ctrl reset");
		rd_reg(COMPARE_B_VALUE_ADDR_VALUE, COMPARE_B_VALUE_VALUE_RESET, "value reset");
		rd_reg(4'h5, 16'h0000, "unmapped");
		$display("test reset done");
		@(posedge clk) apend <= 1'b1;
		wr_reg(COMPARE_B_VALUE_ADDR_VALUE, 16'h0003);
		wr_reg(COMPARE_B_VALUE_ADDR_VALUE, 16'h0004);
		wr_reg(COMPARE_B_VALUE_ADDR_CTRL, 16'hfe04);
		rd_reg(COMPARE_B_VALUE_ADDR_CTRL, 16'h0304, "ctrl pending");
		rd_reg(COMPARE_B_VALUE_ADDR_VALUE, 16'h0004, "shadow value");
		wait_ev(16'h0005);
		chk("out a set", 16'h0001, {15'h0000, pwm_a});
		chk("out b toggle", 16'h0001, {15'h0000, pwm_b});
		rd_reg(COMPARE_B_VALUE_ADDR_CTRL, 16'h0104, "pending cleared");
		$display("test buffered done");
		for (int s = 0; s < 4; s++)
		begin
			wr_reg(COMPARE_B_VALUE_ADDR_CTRL, {12'h000, s[1:0], 2'h0});
			wr_reg(COMPARE_B_VALUE_ADDR_VALUE, 16'h0002);
			run_cycles(9);
			rd_reg(COMPARE_B_VALUE_ADDR_CTRL, {6'h00, s == 3, 5'h10, s[1:0], 2'h0}, "select");
		end
		$display("test load select done");
		@(posedge clk) cfg_a <= COMPARE_B_VALUE_ACT_CLEAR;
		wr_reg(COMPARE_B_VALUE_ADDR_CTRL, 16'h0040);
		wr_reg(COMPARE_B_VALUE_ADDR_VALUE, 16'h0006);
		rd_reg(COMPARE_B_VALUE_ADDR_CTRL, 16'h0140, "no pending");
		wait_ev(16'h0007);
		chk("out a clear", 16'h0000, {15'h0000, pwm_a});
		run_cycles(9);
		rd_reg(COMPARE_B_VALUE_ADDR_VALUE, 16'h0006, "active kept");
		$display("test immediate done");
		end_of_test;
	end
endmodule
`default_nettype wire
